// ==== xbar_pkg.sv ====
package xbar_pkg;
   // pin and signal counts
   localparam int NUM_XPIN = 16;
   localparam int NUM_PIN  = 17;
   localparam int NUM_SIG  = 17;
   localparam int NUM_MOV  = 15;
   localparam int FIRST_MOV = 2;
   localparam int ADDR_W   = 12;
   // signal indices in priority order
   localparam int SIG_TX     = 0;
   localparam int SIG_RX     = 1;
   localparam int SIG_SCK    = 2;
   localparam int SIG_MISO   = 3;
   localparam int SIG_MOSI   = 4;
   localparam int SIG_SSEL   = 5;
   localparam int SIG_SDA    = 6;
   localparam int SIG_SCL    = 7;
   localparam int SIG_CP0    = 8;
   localparam int SIG_CP0A   = 9;
   localparam int SIG_SYSCLK = 10;
   localparam int SIG_COUNTER_ARRAY_COMPARE_OUT   = 11;
   localparam int SIG_CEX1   = 12;
   localparam int SIG_CEX2   = 13;
   localparam int SIG_ECI    = 14;
   localparam int SIG_T0     = 15;
   localparam int SIG_T1     = 16;
   // fixed pins
   localparam logic [15:0] TX_PIN_MASK    = 16'h0010;
   localparam logic [15:0] RX_PIN_MASK    = 16'h0020;
   localparam logic [15:0] SMALL_PKG_MASK = 16'hF000;
   // route_select_reg_a fields
   localparam int A_UART   = 0;
   localparam int A_SPI    = 1;
   localparam int A_SMB    = 2;
   localparam int A_SYSCLK = 3;
   localparam int A_CP0    = 4;
   localparam int A_CP0A   = 5;
   // route_select_reg_b fields
   localparam int B_PCA_LO = 0;
   localparam int B_ECI    = 3;
   localparam int B_T0     = 4;
   localparam int B_T1     = 5;
   localparam int B_XEN    = 6;
   // route_select_reg_c fields
   localparam int C_SSM_LO = 0;
   localparam int C_SMALL  = 2;
   localparam logic [1:0] SSM_3WIRE = 2'h0;
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_ROUTE_A = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_ROUTE_B = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_ROUTE_C = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_SKIP    = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_MODE    = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_LATCH   = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_STATE   = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_EVENT   = 12'h01C;
   // reset values
   localparam logic [7:0]  RST_ROUTE = 8'h00;
   localparam logic [15:0] RST_SKIP  = 16'h0000;
   localparam logic [16:0] RST_MODE  = 17'h1FFFF;
   localparam logic [16:0] RST_LATCH = 17'h1FFFF;
endpackage

// ==== xbar_link.sv ====
`timescale 1ns/1ps
interface xbar_link;
   logic [7:0]                     route_select_reg_a;
   logic [7:0]                     route_select_reg_b;
   logic [7:0]                     route_select_reg_c;
   logic [xbar_pkg::NUM_XPIN-1:0] pin_skip_mask;
   logic [xbar_pkg::NUM_PIN-1:0]  pin_input_mode;
   logic [xbar_pkg::NUM_PIN-1:0]  port_output_latch_bit;
   logic [xbar_pkg::NUM_PIN-1:0]  pin_state;
   logic [xbar_pkg::NUM_PIN-1:0]  pin_event;

   modport device (
      input  route_select_reg_a, route_select_reg_b, route_select_reg_c,
      input  pin_skip_mask, pin_input_mode, port_output_latch_bit,
      output pin_state, pin_event
   );
   modport controller (
      output route_select_reg_a, route_select_reg_b, route_select_reg_c,
      output pin_skip_mask, pin_input_mode, port_output_latch_bit,
      input  pin_state, pin_event
   );
endinterface

// ==== pin_allocator.sv ====
`timescale 1ns/1ps
module pin_allocator #(
   parameter int NSIG = 15,
   parameter int NPIN = 16
) (
   // requests in priority order, lowest index first
   input  wire logic [NSIG-1:0]      req,
   // pins still free for allocation
   input  wire logic [NPIN-1:0]      avail,
   // one-hot pin per signal, zero when none is left
   output logic      [NSIG*NPIN-1:0] grant
);
   logic [NPIN-1:0] free [NSIG+1];
   assign free[0] = avail;

   genvar j;
   generate
      for (j = 0; j < NSIG; j++) begin : g_stage
         logic [NPIN-1:0] lowest;
         // lowest set bit of the free mask
         assign lowest = free[j] & ((~free[j]) + NPIN'(1));
         // an empty mask yields no pin, so no pin is shared
         assign grant[j*NPIN +: NPIN] = req[j] ? lowest : '0;
         assign free[j+1] = free[j] & ~grant[j*NPIN +: NPIN];
      end
   endgenerate
endmodule // pin_allocator

// ==== xbar_device.sv ====
// Overview of operation
// - enabled resources take lowest free pins, priority order
// - pins already taken are passed over
// - skipped pins count as occupied
// - serial transmit P0.4, receive P0.5 always
// - SMBus and serial pins allocated in pairs
// - slave select pinned only in 4-wire mode
// - no skips: SPI lands on P0.0 to P0.3
// - skip P0.0,2,3: SPI P0.1,6,7,P1.0
// - leftover pins stay ordinary port I/O
// - only P0.0-P1.7 routed, P2.0 GPIO only
// - small package lacks P1.4 to P1.7
// - pin transitions raise event capture pulses
// - event capture on digital pins, not analog
// - software skips analog pins
// - software sets latch on analog pins
// - software skips dedicated function pins
// - software skips GPIO and bypass pins
// - enables come from routing registers
// - global enable clear: all pins inputs
// - input mode 1 digital, default digital
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module xbar_device (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // configuration from the controller
   xbar_link.device                          link,
   // peripheral side
   input  wire logic [xbar_pkg::NUM_SIG-1:0] sig_out,
   input  wire logic [xbar_pkg::NUM_SIG-1:0] sig_drive,
   output logic      [xbar_pkg::NUM_SIG-1:0] sig_in,
   // pads
   input  wire logic [xbar_pkg::NUM_PIN-1:0] pad_in,
   output logic      [xbar_pkg::NUM_PIN-1:0] pad_out,
   output logic      [xbar_pkg::NUM_PIN-1:0] pad_oe_n,
   // event capture
   output logic                              event_any
);
   localparam int NS = xbar_pkg::NUM_SIG;
   localparam int NP = xbar_pkg::NUM_PIN;
   localparam int NX = xbar_pkg::NUM_XPIN;
   localparam int NM = xbar_pkg::NUM_MOV;
   localparam int FM = xbar_pkg::FIRST_MOV;

   // decoded enables
   wire       xbar_en  = link.route_select_reg_b[xbar_pkg::B_XEN];
   wire       uart_en  = link.route_select_reg_a[xbar_pkg::A_UART];
   wire       spi_en   = link.route_select_reg_a[xbar_pkg::A_SPI];
   wire       smb_en   = link.route_select_reg_a[xbar_pkg::A_SMB];
   wire [1:0] pca_sel  = link.route_select_reg_b[xbar_pkg::B_PCA_LO +: 2];
   wire [1:0] ssm      = link.route_select_reg_c[xbar_pkg::C_SSM_LO +: 2];
   wire       small_pkg = link.route_select_reg_c[xbar_pkg::C_SMALL];
   wire       four_wire = (ssm != xbar_pkg::SSM_3WIRE);

   logic [NS-1:0] req;
   assign req[xbar_pkg::SIG_TX]     = uart_en;
   assign req[xbar_pkg::SIG_RX]     = uart_en;
   assign req[xbar_pkg::SIG_SCK]    = spi_en;
   assign req[xbar_pkg::SIG_MISO]   = spi_en;
   assign req[xbar_pkg::SIG_MOSI]   = spi_en;
   assign req[xbar_pkg::SIG_SSEL]   = spi_en & four_wire;
   assign req[xbar_pkg::SIG_SDA]    = smb_en;
   assign req[xbar_pkg::SIG_SCL]    = smb_en;
   assign req[xbar_pkg::SIG_CP0]    = link.route_select_reg_a[xbar_pkg::A_CP0];
   assign req[xbar_pkg::SIG_CP0A]   = link.route_select_reg_a[xbar_pkg::A_CP0A];
   assign req[xbar_pkg::SIG_SYSCLK] = link.route_select_reg_a[xbar_pkg::A_SYSCLK];
   assign req[xbar_pkg::SIG_COUNTER_ARRAY_COMPARE_OUT]   = (pca_sel != 2'h0);
   assign req[xbar_pkg::SIG_CEX1]   = pca_sel[1];
   assign req[xbar_pkg::SIG_CEX2]   = (pca_sel == 2'h3);
   assign req[xbar_pkg::SIG_ECI]    = link.route_select_reg_b[xbar_pkg::B_ECI];
   assign req[xbar_pkg::SIG_T0]     = link.route_select_reg_b[xbar_pkg::B_T0];
   assign req[xbar_pkg::SIG_T1]     = link.route_select_reg_b[xbar_pkg::B_T1];

   // serial pins are reserved before the scan, skip bits do not move them
   wire [NX-1:0] uart_pins = uart_en ? (xbar_pkg::TX_PIN_MASK | xbar_pkg::RX_PIN_MASK)
                                     : '0;
   wire [NX-1:0] pkg_gone  = small_pkg ? xbar_pkg::SMALL_PKG_MASK : '0;
   wire [NX-1:0] avail     = ~link.pin_skip_mask & ~uart_pins & ~pkg_gone;

   logic [NM*NX-1:0] grant_mov;

   pin_allocator #(
      .NSIG (NM),
      .NPIN (NX)
   ) u_alloc (
      .req   (req[NS-1:FM]),
      .avail (avail),
      .grant (grant_mov)
   );

   // full grant matrix, row per signal, pin P2.0 never in it
   logic [NX-1:0] gmat   [NS];
   logic [NS-1:0] by_pin [NX];

   assign gmat[xbar_pkg::SIG_TX] = uart_en ? xbar_pkg::TX_PIN_MASK : '0;
   assign gmat[xbar_pkg::SIG_RX] = uart_en ? xbar_pkg::RX_PIN_MASK : '0;

   genvar s, p;
   generate
      for (s = FM; s < NS; s++) begin : g_row
         assign gmat[s] = grant_mov[(s-FM)*NX +: NX];
      end
      for (p = 0; p < NX; p++) begin : g_col
         for (s = 0; s < NS; s++) begin : g_bit
            assign by_pin[p][s] = gmat[s][p];
         end
      end
   endgenerate

   // pin input synchroniser, three stages with agreement filter
   logic [NP-1:0] sync1_reg;
   logic [NP-1:0] sync2_reg;
   logic [NP-1:0] sync3_reg;
   logic [NP-1:0] level_reg;
   logic [NP-1:0] level_next;
   wire  [NP-1:0] agree = ~(sync2_reg ^ sync3_reg);

   // hold the old level while the last two stages disagree
   assign level_next = (agree & sync3_reg) | (~agree & level_reg);

   // analog pins read zero and never raise events
   wire [NP-1:0] digital   = link.pin_input_mode;
   wire [NP-1:0] state_nx  = level_next & digital;
   wire [NP-1:0] event_nx  = (level_next ^ level_reg) & digital;

   // pad drive per pin
   logic [NP-1:0] out_nx;
   logic [NP-1:0] oen_nx;
   logic [NS-1:0] in_nx;

   generate
      for (p = 0; p < NX; p++) begin : g_pin
         wire owned = |by_pin[p];
         wire val   = |(by_pin[p] & sig_out);
         wire drv   = |(by_pin[p] & sig_drive);
         wire lost  = pkg_gone[p];
         wire latch = link.port_output_latch_bit[p];
         // gpio pins only pull low, so an analog pin needs its latch set
         assign out_nx[p] = owned ? val : latch;
         assign oen_nx[p] = !xbar_en ? 1'b1 :
                            owned    ? ~drv :
                            lost     ? 1'b1 :
                            latch;
      end
      // a signal with no pin reads zero rather than a stale pad
      for (s = 0; s < NS; s++) begin : g_in
         assign in_nx[s] = xbar_en & |(gmat[s] & level_next[NX-1:0] & digital[NX-1:0]);
      end
   endgenerate

   // the top pin is plain port I/O, never routed
   assign out_nx[NP-1] = link.port_output_latch_bit[NP-1];
   assign oen_nx[NP-1] = !xbar_en | link.port_output_latch_bit[NP-1];

   // three-stage capture of the asynchronous pads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= pad_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // a one-cycle glitch never reaches level_reg, so it raises no event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= '0;
      end else begin
         level_reg <= level_next;
      end
   end

   // pad drive registered, so no pad sees a decode glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out  <= '1;
         pad_oe_n <= '1;
      end else begin
         pad_out  <= out_nx;
         pad_oe_n <= oen_nx;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_in <= '0;
      end else begin
         sig_in <= in_nx;
      end
   end

   // event status towards the controller
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.pin_state <= '0;
         link.pin_event <= '0;
         event_any      <= 1'b0;
      end else begin
         link.pin_state <= state_nx;
         link.pin_event <= event_nx;
         event_any      <= |event_nx;
      end
   end
endmodule // xbar_device

// ==== xbar_controller.sv ====
`timescale 1ns/1ps
module xbar_controller (
   // clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // apb slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [xbar_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   // configuration towards the crossbar
   xbar_link.controller                        link
);
   localparam int NP = xbar_pkg::NUM_PIN;
   localparam int NX = xbar_pkg::NUM_XPIN;

   logic [7:0]    route_a_reg;
   logic [7:0]    route_b_reg;
   logic [7:0]    route_c_reg;
   logic [NX-1:0] skip_reg;
   logic [NP-1:0] mode_reg;
   logic [NP-1:0] latch_reg;
   logic [NP-1:0] event_reg;

   // address decode
   wire hit_a     = (paddr == xbar_pkg::OFS_ROUTE_A);
   wire hit_b     = (paddr == xbar_pkg::OFS_ROUTE_B);
   wire hit_c     = (paddr == xbar_pkg::OFS_ROUTE_C);
   wire hit_skip  = (paddr == xbar_pkg::OFS_SKIP);
   wire hit_mode  = (paddr == xbar_pkg::OFS_MODE);
   wire hit_latch = (paddr == xbar_pkg::OFS_LATCH);
   wire hit_state = (paddr == xbar_pkg::OFS_STATE);
   wire hit_event = (paddr == xbar_pkg::OFS_EVENT);
   wire mapped    = hit_a | hit_b | hit_c | hit_skip | hit_mode | hit_latch
                    | hit_state | hit_event;

   // zero-wait: answer prepared in setup, ready in the first access cycle
   wire setup = psel & ~penable;
   wire wr    = psel & penable & pready & pwrite & ~pslverr;

   wire [31:0] rd_data =
      hit_a     ? {24'h000000, route_a_reg} :
      hit_b     ? {24'h000000, route_b_reg} :
      hit_c     ? {24'h000000, route_c_reg} :
      hit_skip  ? {16'h0000, skip_reg} :
      hit_mode  ? {15'h0000, mode_reg} :
      hit_latch ? {15'h0000, latch_reg} :
      hit_state ? {15'h0000, link.pin_state} :
      hit_event ? {15'h0000, event_reg} : 32'h00000000;

   // write-one-to-clear, a new event in the same cycle wins
   wire [NP-1:0] ev_clr  = (wr & hit_event) ? pwdata[NP-1:0] : '0;
   wire [NP-1:0] ev_next = (event_reg & ~ev_clr) | link.pin_event;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup & ~pwrite) ? rd_data : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_a_reg <= xbar_pkg::RST_ROUTE;
         route_b_reg <= xbar_pkg::RST_ROUTE;
         route_c_reg <= xbar_pkg::RST_ROUTE;
         skip_reg    <= xbar_pkg::RST_SKIP;
         mode_reg    <= xbar_pkg::RST_MODE;
         latch_reg   <= xbar_pkg::RST_LATCH;
         event_reg   <= '0;
      end else begin
         if (wr & hit_a) route_a_reg <= pwdata[7:0] & 8'h3F;
         if (wr & hit_b) route_b_reg <= pwdata[7:0] & 8'hFB;
         if (wr & hit_c) route_c_reg <= pwdata[7:0] & 8'h07;
         if (wr & hit_skip) skip_reg <= pwdata[NX-1:0];
         if (wr & hit_mode) mode_reg <= pwdata[NP-1:0];
         if (wr & hit_latch) latch_reg <= pwdata[NP-1:0];
         event_reg <= ev_next;
      end
   end

   assign link.route_select_reg_a    = route_a_reg;
   assign link.route_select_reg_b    = route_b_reg;
   assign link.route_select_reg_c    = route_c_reg;
   assign link.pin_skip_mask         = skip_reg;
   assign link.pin_input_mode        = mode_reg;
   assign link.port_output_latch_bit = latch_reg;
endmodule // xbar_controller

// ==== xbar_chk.sv ====
`timescale 1ns/1ps
module xbar_chk (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // configuration from the controller
   input wire logic [7:0]  route_select_reg_a,
   input wire logic [7:0]  route_select_reg_b,
   input wire logic [7:0]  route_select_reg_c,
   input wire logic [15:0] pin_skip_mask,
   input wire logic [16:0] pin_input_mode,
   input wire logic [16:0] port_output_latch_bit,
   // pin status from the device
   input wire logic [16:0] pin_state,
   input wire logic [16:0] pin_event
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // only digital pins that stayed digital count, mode flips may move the level
   sequence s_level_moved;
      ((pin_state ^ $past(pin_state)) & $past(pin_input_mode)
         & $past(pin_input_mode, 2)) != '0;
   endsequence
   sequence s_event_soon;
      ##[0:2] (pin_event != '0);
   endsequence

   a_edge_raises_event :
   assert property (s_level_moved |-> s_event_soon)
      else $error("pin edge without event");
   a_event_has_cause :
   assert property (pin_event != '0 |-> pin_state != $past(pin_state)
      || $past(pin_state) != $past(pin_state, 2) || $past(pin_state, 2) != $past(pin_state, 3))
      else $error("event without pin edge");
   a_event_one_cycle :
   assert property ((pin_event & $past(pin_event)) == '0)
      else $error("event longer than one cycle");
   a_analog_state_low :
   assert property ((pin_state & ~pin_input_mode & ~$past(pin_input_mode)
      & ~$past(pin_input_mode, 2)) == '0)
      else $error("analog pin shows a level");
   a_analog_no_event :
   assert property ((pin_event & ~pin_input_mode & ~$past(pin_input_mode)
      & ~$past(pin_input_mode, 2)) == '0)
      else $error("event on analog pin");
   a_reset_config :
   assert property ($rose(presetn) |-> route_select_reg_a == 8'h00
      && route_select_reg_b == 8'h00 && route_select_reg_c == 8'h00
      && pin_skip_mask == xbar_pkg::RST_SKIP && pin_input_mode == xbar_pkg::RST_MODE
      && port_output_latch_bit == xbar_pkg::RST_LATCH)
      else $error("configuration not at reset value");
   a_quiet_after_reset :
   assert property ($rose(presetn) |-> pin_event == '0 ##1 pin_event == '0)
      else $error("event right after reset");
endmodule // xbar_chk

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   // apb side
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, err, event_any, seen;
   // peripheral and pad side
   logic [16:0] sig_out = '0, sig_drive = '1, sig_in, pad_in = '0;
   logic [16:0] pad_out, pad_oe_n, latch_now = 17'h1FFFF;
   int          num_errors = 0, num_checks = 0, cycles = 0;

   xbar_link xbar_link_i ();
   xbar_controller xbar_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(xbar_link_i));
   xbar_device xbar_device_i (.pclk(pclk), .presetn(presetn), .link(xbar_link_i),
      .sig_out(sig_out), .sig_drive(sig_drive), .sig_in(sig_in), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .event_any(event_any));
   xbar_chk xbar_chk_i (.pclk(pclk), .presetn(presetn),
      .route_select_reg_a(xbar_link_i.route_select_reg_a),
      .route_select_reg_b(xbar_link_i.route_select_reg_b),
      .route_select_reg_c(xbar_link_i.route_select_reg_c),
      .pin_skip_mask(xbar_link_i.pin_skip_mask),
      .pin_input_mode(xbar_link_i.pin_input_mode),
      .port_output_latch_bit(xbar_link_i.port_output_latch_bit),
      .pin_state(xbar_link_i.pin_state), .pin_event(xbar_link_i.pin_event));

   always #50 pclk = ~pclk;

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   // waits for pready with no assumed latency
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rdat = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic setup(input logic [7:0] a, b, c, input logic [15:0] s);
      apb(1'h1, xbar_pkg::OFS_SKIP, {16'h0, s});
      apb(1'h1, xbar_pkg::OFS_ROUTE_C, {24'h0, c});
      apb(1'h1, xbar_pkg::OFS_ROUTE_B, {24'h0, b});
      apb(1'h1, xbar_pkg::OFS_ROUTE_A, {24'h0, a});
      repeat (2) @(posedge pclk);
   endtask

   // unowned pins follow the latch, missing pins never drive
   task automatic pads(input logic [16:0] owned, dead);
      chk("pad_oe_n", 32'((owned & ~sig_drive) | (~owned & latch_now) | dead), 32'(pad_oe_n));
      chk("pad_out", 32'(((owned & {17{sig_out[0]}}) | (~owned & latch_now)) & ~dead),
          32'(pad_out & ~dead));
   endtask

   // own[p] is the signal expected on pin p, -1 for none
   task automatic map(input int own[16], input logic [16:0] dead);
      logic [16:0] owned = '0;
      for (int p = 0; p < 16; p++) begin
         owned[p] = own[p] >= 0;
      end
      pads(owned, dead);
      for (int p = 0; p < 16; p++) begin
         pad_in <= 17'h1 << p;
         repeat (6) @(posedge pclk);
         chk("sig_in", own[p] >= 0 ? 32'h1 << own[p] : 32'h0, 32'(sig_in));
      end
      pad_in <= '0;
      repeat (6) @(posedge pclk);
   endtask

   task automatic reset_regs();
      for (int k = 0; k < 6; k++) begin
         apb(1'h0, 12'(4 * k), 32'h0);
         chk("reset value", k < 4 ? 32'h0 : 32'(xbar_pkg::RST_MODE), rdat);
      end
      apb(1'h0, 12'h020, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rdat);
   endtask

   // routing bits set and latch low, yet nothing may drive
   task automatic crossbar_off();
      apb(1'h1, xbar_pkg::OFS_LATCH, 32'h0);
      setup(8'h3F, 8'h3B, 8'h01, 16'h0000);
      pad_in <= '1;
      repeat (6) @(posedge pclk);
      chk("pad_oe_n off", 32'h1FFFF, 32'(pad_oe_n));
      chk("sig_in off", 32'h0, 32'(sig_in));
      pad_in <= '0;
      apb(1'h1, xbar_pkg::OFS_LATCH, 32'h1FFFF);
   endtask

   // pin 8 analog, skipped, latch set; pin 9 crossbar-owned; P2.0 latch clear, so it drives low
   task automatic events();
      seen = 1'h0;
      apb(1'h1, xbar_pkg::OFS_EVENT, 32'h1FFFF);
      apb(1'h1, xbar_pkg::OFS_SKIP, 32'h00100);
      apb(1'h1, xbar_pkg::OFS_LATCH, 32'h00100);
      apb(1'h1, xbar_pkg::OFS_MODE, 32'h1FEFF);
      pad_in <= 17'h10300;
      repeat (8) begin
         @(posedge pclk);
         if (event_any === 1'h1) seen = 1'h1;
      end
      chk("event_any", 32'h1, 32'(seen));
      apb(1'h0, xbar_pkg::OFS_STATE, 32'h0);
      chk("pin state", 32'h10200, rdat);
      apb(1'h0, xbar_pkg::OFS_EVENT, 32'h0);
      chk("event flags", 32'h10200, rdat);
      apb(1'h1, xbar_pkg::OFS_EVENT, 32'h10200);
      apb(1'h0, xbar_pkg::OFS_EVENT, 32'h0);
      chk("event cleared", 32'h0, rdat);
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      reset_regs();
      crossbar_off();
      setup(8'h03, 8'h43, 8'h01, 16'h0000);
      map('{2, 3, 4, 5, 0, 1, 11, 12, 13, -1, -1, -1, -1, -1, -1, -1}, '0);
      setup(8'h03, 8'h43, 8'h01, 16'h000D);
      map('{-1, 2, -1, -1, 0, 1, 3, 4, 5, 11, 12, 13, -1, -1, -1, -1}, '0);
      setup(8'h02, 8'h43, 8'h00, 16'h0000);
      map('{2, 3, 4, 11, 12, 13, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1}, '0);
      setup(8'h0F, 8'h43, 8'h01, 16'hFF00);
      map('{2, 3, 4, 5, 0, 1, 6, 7, -1, -1, -1, -1, -1, -1, -1, -1}, '0);
      setup(8'h3F, 8'h7B, 8'h05, 16'h0000);
      map('{2, 3, 4, 5, 0, 1, 6, 7, 8, 9, 10, 11, -1, -1, -1, -1}, 17'h0F000);
      latch_now = 17'h0;
      apb(1'h1, xbar_pkg::OFS_LATCH, 32'h0);
      sig_out <= '1;
      repeat (2) @(posedge pclk);
      pads(17'h00FFF, 17'h0F000);
      events();
      end_sim();
   end
endmodule // testbench
